/* src/clock_source_routing_config.sv */
`timescale 1ns/10ps
`include "clk_route_defs.svh"
module clock_source_routing_config (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic extClkIn,
   input wire logic oscClkIn,
   output logic distClkOut,
   output logic feedbackClkOut,
   output logic loopPowerDown,
   output logic oscPowerDown,
   output logic pdPolarityNeg,
   output logic calStart,
   output logic calBusy
);
   import clk_route_pkg::*;

   localparam int CAL_CYCLES = `CAL_CYCLES;
   localparam int CALW = $clog2(CAL_CYCLES + 1);

   bus_state_e state;
   bus_state_e next_state;
   regidx_t addrIdx;
   regidx_t next_addrIdx;
   logic addrOk;
   logic next_addrOk;
   logic [31:0] next_hrdata;
   logic accept;

   reg_t loopReg;
   reg_t calStage;
   reg_t calReg;
   reg_t divReg;
   reg_t srcReg;
   reg_t next_loopReg;
   reg_t next_calStage;
   reg_t next_calReg;
   reg_t next_divReg;
   reg_t next_srcReg;
   logic [CALW-1:0] calCnt;
   logic [CALW-1:0] next_calCnt;
   logic next_calStart;
   logic next_calBusy;
   logic wrEn;

   logic srcLevel;
   logic divOut;
   ratio_t ratio;
   logic next_distClkOut;
   logic next_feedbackClkOut;
   logic next_loopPowerDown;
   logic next_oscPowerDown;
   logic next_pdPolarityNeg;

   // Map a divider code onto its ratio; codes past the top hold at 6
   function automatic ratio_t ratioOf(input logic [2:0] code);
      if (code > `RATIO_CODE_MAX) begin
         return `RATIO_MAX;
      end
      return ratio_t'(code + `RATIO_MIN);
   endfunction

   // True for an aligned word inside the 4 KiB window
   function automatic logic addrHit(input logic [31:0] a,
                                    input logic [2:0] sz);
      return (a[31:12] == 20'h00000) && (a[1:0] == 2'h0) && (sz == 3'h2);
   endfunction

   // Register read mux; unmapped indices read zero
   function automatic logic [31:0] regRead(input regidx_t idx,
                                           input logic ok);
      logic [7:0] v;
      v = 8'h00;
      if (ok) begin
         case (idx)
            `IDX_LOOP: v = loopReg;
            `IDX_CAL: v = calStage;
            `IDX_DIV: v = divReg;
            `IDX_SRC: v = srcReg;
            `IDX_STAT: v = {1'b0, ratio, oscPowerDown, loopPowerDown,
                            calReg[`CAL_BIT], calBusy};
            default: v = 8'h00;
         endcase
      end
      return {24'h000000, v};
   endfunction

   // Ready drops for the single read wait state and whenever frozen
   assign hreadyout = ce && (state != BUS_RDWAIT);
   assign hresp = 1'b0;
   assign accept = hsel && htrans[1] && hready;

   // Bus phase tracking; read data comes from a flop after one wait
   always_comb begin
      next_state = state;
      next_addrIdx = addrIdx;
      next_addrOk = addrOk;
      next_hrdata = hrdata;
      case (state)
         BUS_IDLE, BUS_WRITE, BUS_RDDATA: begin
            if (accept) begin
               next_state = hwrite ? BUS_WRITE : BUS_RDWAIT;
               next_addrIdx = haddr[11:2];
               next_addrOk = addrHit(haddr, hsize);
            end else begin
               next_state = BUS_IDLE;
            end
         end
         BUS_RDWAIT: begin
            next_state = BUS_RDDATA;
            next_hrdata = regRead(addrIdx, addrOk);
         end
         default: next_state = BUS_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         state <= BUS_IDLE;
         addrIdx <= '0;
         addrOk <= 1'b0;
         hrdata <= 32'h00000000;
      end else if (ce) begin
         state <= next_state;
         addrIdx <= next_addrIdx;
         addrOk <= next_addrOk;
         hrdata <= next_hrdata;
      end
   end

   assign wrEn = (state == BUS_WRITE) && addrOk;

   // Register writes; calibration bit only acts on an update strobe
   always_comb begin
      next_loopReg = loopReg;
      next_calStage = calStage;
      next_calReg = calReg;
      next_divReg = divReg;
      next_srcReg = srcReg;
      next_calStart = 1'b0;
      next_calCnt = calCnt;
      if (calCnt != '0) begin
         next_calCnt = CALW'(calCnt - 1'b1);
      end
      if (wrEn) begin
         case (addrIdx)
            `IDX_LOOP: next_loopReg = hwdata[7:0];
            `IDX_CAL: next_calStage = hwdata[7:0];
            `IDX_DIV: next_divReg = hwdata[7:0];
            `IDX_SRC: next_srcReg = hwdata[7:0];
            `IDX_UPD: begin
               if (hwdata[`UPD_BIT]) begin
                  next_calReg = calStage;
                  // Start only on a 0 to 1 step, so a stale 1 never reruns
                  if (calStage[`CAL_BIT] && !calReg[`CAL_BIT]) begin
                     next_calStart = 1'b1;
                     next_calCnt = CALW'(CAL_CYCLES);
                  end
               end
            end
            default: next_loopReg = loopReg;
         endcase
      end
      next_calBusy = (next_calCnt != '0);
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         loopReg <= `RST_LOOP;
         calStage <= `RST_CAL;
         calReg <= `RST_CAL;
         divReg <= `RST_DIV;
         srcReg <= `RST_SRC;
         calCnt <= '0;
         calStart <= 1'b0;
         calBusy <= 1'b0;
      end else if (ce) begin
         loopReg <= next_loopReg;
         calStage <= next_calStage;
         calReg <= next_calReg;
         divReg <= next_divReg;
         srcReg <= next_srcReg;
         calCnt <= next_calCnt;
         calStart <= next_calStart;
         calBusy <= next_calBusy;
      end
   end

   // Source choice feeds both the divider and the bypass path
   assign srcLevel = srcReg[`OSC_SEL_BIT] ? oscClkIn : extClkIn;
   assign ratio = ratioOf(divReg[`DIV_MSB:0]);

   prescale_divider #(
      .CW(3)
   ) u_div (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .srcLevel(srcLevel),
      .ratio(ratio),
      .divOut(divOut)
   );

   // Routing and power outputs, all registered
   always_comb begin
      next_distClkOut = srcReg[`BYPASS_BIT] ? srcLevel : divOut;
      next_loopPowerDown =
         (loopReg[`LOOP_PWR_MSB:`LOOP_PWR_LSB] != `LOOP_ON);
      next_oscPowerDown = !srcReg[`OSC_SEL_BIT];
      next_pdPolarityNeg = loopReg[`POL_BIT];
      // Selected source goes straight to feedback while loop runs
      next_feedbackClkOut = !next_loopPowerDown && srcLevel;
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         distClkOut <= 1'b0;
         feedbackClkOut <= 1'b0;
         loopPowerDown <= 1'b1;
         oscPowerDown <= 1'b1;
         pdPolarityNeg <= 1'b0;
      end else if (ce) begin
         distClkOut <= next_distClkOut;
         feedbackClkOut <= next_feedbackClkOut;
         loopPowerDown <= next_loopPowerDown;
         oscPowerDown <= next_oscPowerDown;
         pdPolarityNeg <= next_pdPolarityNeg;
      end
   end

   // Checks on routing, power, register defaults, divider ratio, calibration busy and read wait
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   reset_defaults_a: assert property (
      $past(!rstn) |-> loopReg == `RST_LOOP && divReg == `RST_DIV &&
         srcReg == `RST_SRC)
      else $error("register defaults wrong after reset");

   power_up_mode_a: assert property (
      $past(!rstn) |-> loopPowerDown && oscPowerDown &&
         !srcReg[`BYPASS_BIT] && ratio == 3'h4)
      else $error("power-up mode is not distribution through divider");

   loop_power_map_a: assert property (
      ce |=> loopPowerDown ==
         ($past(loopReg[`LOOP_PWR_MSB:`LOOP_PWR_LSB]) != `LOOP_ON))
      else $error("loop power output does not follow its field");

   polarity_out_a: assert property (
      ce |=> pdPolarityNeg == $past(loopReg[`POL_BIT]))
      else $error("polarity output does not follow its bit");

   osc_power_a: assert property (
      ce && !srcReg[`OSC_SEL_BIT] |=> oscPowerDown)
      else $error("oscillator powered while clock input is source");

   bypass_path_a: assert property (
      ce && srcReg[`BYPASS_BIT] |=> distClkOut == $past(srcLevel))
      else $error("bypass path does not carry the source");

   divided_path_a: assert property (
      ce && !srcReg[`BYPASS_BIT] |=> distClkOut == $past(divOut))
      else $error("divided path does not carry the divider");

   src_select_a: assert property (
      ce && srcReg[`BYPASS_BIT] && srcReg[`OSC_SEL_BIT]
         |=> distClkOut == $past(oscClkIn))
      else $error("oscillator source not routed");

   feedback_a: assert property (
      ce && loopReg[`LOOP_PWR_MSB:`LOOP_PWR_LSB] == `LOOP_ON &&
         !srcReg[`OSC_SEL_BIT] |=> feedbackClkOut == $past(extClkIn))
      else $error("external oscillator not fed to feedback");

   ratio_floor_a: assert property (
      ratio >= `RATIO_MIN && ratio <= `RATIO_MAX &&
         (divReg[`DIV_MSB:0] <= `RATIO_CODE_MAX ||
          ratio == `RATIO_MAX))
      else $error("divider ratio out of range");

   cal_busy_a: assert property (
      calStart |-> calBusy [*8] ##1 calBusy [*8])
      else $error("calibration busy not held after start");

   read_wait_a: assert property (
      accept && ce && !hwrite |=> !hreadyout ##1 (!ce || hreadyout))
      else $error("read wait state wrong");

   bypass_osc_c: cover property (ce && srcReg[`BYPASS_BIT] &&
      srcReg[`OSC_SEL_BIT]);
   cal_start_c: cover property (calStart);
   loop_ext_c: cover property (!loopPowerDown && oscPowerDown);
   read_back_c: cover property (state == BUS_RDDATA && hrdata != 32'h0);
endmodule // clock_source_routing_config

/* src/clk_route_defs.svh */
`ifndef CLK_ROUTE_DEFS_SVH
`define CLK_ROUTE_DEFS_SVH
// Register indices; byte address is four times the index
`define IDX_LOOP 10'h010
`define IDX_CAL 10'h018
`define IDX_DIV 10'h1e0
`define IDX_SRC 10'h1e1
`define IDX_UPD 10'h232
`define IDX_STAT 10'h234
// Reset values
`define RST_LOOP 8'h01
`define RST_CAL 8'h00
`define RST_DIV 8'h02
`define RST_SRC 8'h00
// Field positions and codes
`define LOOP_PWR_MSB 1
`define LOOP_PWR_LSB 0
`define LOOP_ON 2'h0
`define LOOP_OFF 2'h1
`define POL_BIT 7
`define DIV_MSB 2
`define BYPASS_BIT 0
`define OSC_SEL_BIT 1
`define CAL_BIT 0
`define UPD_BIT 0
`define RATIO_MIN 3'h2
`define RATIO_MAX 3'h6
`define RATIO_CODE_MAX 3'h4
// Calibration busy time in ns and the clock period in ns
`define CAL_TIME_NS 1600
`define CLK_PERIOD_NS 100
`define CAL_CYCLES ((`CAL_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* src/clk_route_pkg.sv */
package clk_route_pkg;
   typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_RDWAIT, BUS_RDDATA}
      bus_state_e;
   typedef logic [2:0] ratio_t;
   typedef logic [7:0] reg_t;
   typedef logic [9:0] regidx_t;
endpackage

/* src/prescale_divider.sv */
`timescale 1ns/10ps
`include "clk_route_defs.svh"
module prescale_divider #(
   parameter int CW = 3
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic srcLevel,
   input wire clk_route_pkg::ratio_t ratio,
   output logic divOut
);
   import clk_route_pkg::*;

   logic srcPrev;
   logic next_srcPrev;
   logic [CW-1:0] cnt;
   logic [CW-1:0] next_cnt;
   logic next_divOut;
   ratio_t eff;

   // Guard against a ratio below the floor even if the caller slips
   function automatic ratio_t clampRatio(input ratio_t r);
      if (r < `RATIO_MIN) begin
         return `RATIO_MIN;
      end else if (r > `RATIO_MAX) begin
         return `RATIO_MAX;
      end
      return r;
   endfunction

   assign eff = clampRatio(ratio);

   // Count source rising edges; high for the first ratio/2 counts of each period, rounded down
   always_comb begin
      next_srcPrev = srcLevel;
      next_cnt = cnt;
      next_divOut = divOut;
      if (srcLevel && !srcPrev) begin
         if (cnt >= CW'(eff - 3'h1)) begin
            next_cnt = '0;
         end else begin
            next_cnt = CW'(cnt + 1'b1);
         end
         next_divOut = (next_cnt < CW'(eff >> 1));
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         srcPrev <= 1'b0;
         cnt <= '0;
         divOut <= 1'b0;
      end else if (ce) begin
         srcPrev <= next_srcPrev;
         cnt <= next_cnt;
         divOut <= next_divOut;
      end
   end
endmodule // prescale_divider

/* tb/clk_source_model.sv */
`timescale 1ns/10ps
module clk_source_model (
   input wire logic clk,
   input wire logic rstn,
   output logic extClkIn,
   output logic oscClkIn
);
   logic [1:0] phase;
   // Free-running sources; each pattern differs so a wrong select shows
   always @(posedge clk) begin
      if (!rstn) begin
         phase <= 2'h0;
      end else begin
         phase <= phase + 2'h1;
      end
   end
   // External source at the fastest rate the sampler can see
   assign extClkIn = phase[0];
   assign oscClkIn = phase[1];
endmodule // clk_source_model

/* tb/tb_clock_source_routing_config.sv */
`timescale 1ns/10ps
`include "clk_route_defs.svh"
module tb_clock_source_routing_config;
   import clk_route_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic ce = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout, hresp, distClkOut, feedbackClkOut, loopPowerDown;
   logic oscPowerDown, pdPolarityNeg, calStart, calBusy, extClkIn, oscClkIn;
   int mismatches = 0;
   int numChecks = 0;
   reg_t rd;
   // Free-running bench clock, 100 ns period
   always #50 clk = ~clk;
   clock_source_routing_config u_dut (.clk(clk), .rstn(rstn), .ce(ce),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .extClkIn(extClkIn), .oscClkIn(oscClkIn), .distClkOut(distClkOut),
      .feedbackClkOut(feedbackClkOut), .loopPowerDown(loopPowerDown),
      .oscPowerDown(oscPowerDown), .pdPolarityNeg(pdPolarityNeg),
      .calStart(calStart), .calBusy(calBusy));
   clk_source_model u_src (.clk(clk), .rstn(rstn), .extClkIn(extClkIn),
      .oscClkIn(oscClkIn));
   task report_and_stop;
      $display("checks %0d mismatches %0d", numChecks, mismatches);
      if (mismatches == 0 && numChecks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task chk(input string name, input logic [31:0] seen,
            input logic [31:0] exp);
      numChecks++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Look at hready before the edge so the edge itself never races
   task waitReady;
      int n;
      @(negedge clk);
      for (n = 0; hreadyout !== 1'b1; n++) begin
         if (n == 40) begin
            mismatches++;
            report_and_stop;
         end
         @(negedge clk);
      end
      @(posedge clk);
   endtask
   task ahb(input regidx_t idx, input logic wr, input reg_t wd,
            output reg_t rv);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {20'h0, idx, 2'h0};
      htrans <= 2'h2;
      hwrite <= wr;
      waitReady;
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      waitReady;
      rv = hrdata[7:0];
      chk("hresp", hresp, 1'b0);
   endtask
   task wrReg(input regidx_t idx, input reg_t d);
      ahb(idx, 1'b1, d, rd);
   endtask
   task chkReg(input regidx_t idx, input reg_t exp);
      ahb(idx, 1'b0, 8'h00, rd);
      chk("register", rd, exp);
   endtask
   task testReset;
      @(negedge clk);
      chk("loopPowerDown", loopPowerDown, 1'b1);
      chk("oscPowerDown", oscPowerDown, 1'b1);
      chk("pdPolarityNeg", pdPolarityNeg, 1'b0);
      chkReg(`IDX_LOOP, 8'h01);
      chkReg(`IDX_DIV, 8'h02);
      chkReg(`IDX_SRC, 8'h00);
      chkReg(`IDX_CAL, 8'h00);
      chkReg(`IDX_STAT, 8'h4c);
      wrReg(10'h100, 8'h5a);
      chkReg(10'h100, 8'h00);
      chkReg(`IDX_UPD, 8'h00);
   endtask
   // Gap between two later rises; the first rise may be a transient
   task riseGap(output int p);
      int n, k;
      int t[3];
      logic prev;
      prev = distClkOut;
      k = 0;
      for (n = 0; n < 200 && k < 3; n++) begin
         @(negedge clk);
         if (prev === 1'b0 && distClkOut === 1'b1) begin
            t[k] = n;
            k++;
         end
         prev = distClkOut;
      end
      if (k < 3) begin
         mismatches++;
         report_and_stop;
      end
      p = t[2] - t[1];
   endtask
   // Source toggles each cycle, so ratio N gives a 2N cycle period
   task testDivider;
      int p, code, ratio;
      riseGap(p);
      chk("defaultPeriod", p, 8);
      for (code = 0; code < 8; code++) begin
         wrReg(`IDX_DIV, code[7:0]);
         ratio = (code > 4) ? 6 : code + 2;
         riseGap(p);
         chk("divPeriod", p, 2 * ratio);
      end
   endtask
   task testFollow(input reg_t srcVal, input logic osc);
      logic prev;
      wrReg(`IDX_SRC, srcVal);
      wrReg(`IDX_LOOP, 8'h00);
      repeat (3) @(negedge clk);
      chk("oscPowerDown", oscPowerDown, !osc);
      chk("loopPowerDown", loopPowerDown, 1'b0);
      chk("pdPolarityNeg", pdPolarityNeg, 1'b0);
      prev = osc ? oscClkIn : extClkIn;
      repeat (8) begin
         @(negedge clk);
         chk("distClkOut", distClkOut, prev);
         chk("feedbackClkOut", feedbackClkOut, prev);
         prev = osc ? oscClkIn : extClkIn;
      end
      wrReg(`IDX_LOOP, 8'h81);
      repeat (3) @(negedge clk);
      chk("pdPolarityNeg", pdPolarityNeg, 1'b1);
      chk("loopPowerDown", loopPowerDown, 1'b1);
      chk("feedbackClkOut", feedbackClkOut, 1'b0);
   endtask
   // Count start pulses and busy cycles after an update strobe
   task calRun(input int expStarts, input int expBusy);
      int s, b;
      s = 0;
      b = 0;
      wrReg(`IDX_UPD, 8'h01);
      repeat (24) begin
         @(negedge clk);
         s += (calStart === 1'b1);
         b += (calBusy === 1'b1);
      end
      chk("calStart", s, expStarts);
      chk("calBusy", b, expBusy);
   endtask
   task testCal;
      wrReg(`IDX_SRC, 8'h02);
      wrReg(`IDX_CAL, 8'h01);
      calRun(1, `CAL_CYCLES);
      calRun(0, 0);
      wrReg(`IDX_CAL, 8'h00);
      calRun(0, 0);
      wrReg(`IDX_CAL, 8'h01);
      calRun(1, `CAL_CYCLES);
   endtask
   // Main sequence; reset is held for ten cycles first
   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      testReset;
      testDivider;
      testFollow(8'h01, 1'b0);
      testFollow(8'h03, 1'b1);
      testCal;
      // Second reset in mid-run must bring every default back
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      testReset;
      report_and_stop;
   end
endmodule // tb_clock_source_routing_config
